// ==== logic/wake_gate_pkg.sv ====
// Constants for the wake-up delay sequencer and the peripheral clock gate bank.
`default_nettype none
package wake_gate_pkg;
    // ****************************************************************
    // Register map, byte addresses on the plain register port.
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] ADDR_GATE0 = 8'h00;
    localparam logic [7:0] ADDR_CLKCFG = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    // ****************************************************************
    // Field layouts and reset values.
    // ****************************************************************
    localparam logic [7:0] GATE0_RESET = 8'h00;
    localparam int CFG_RUN_LSB = 0;
    localparam int CFG_PRI_LSB = 2;
    localparam int CFG_FREQ_LSB = 4;
    localparam int CFG_IDLE_BIT = 7;
    localparam logic [1:0] RUN_PRIMARY = 2'h0;
    localparam logic [1:0] RUN_SECONDARY = 2'h1;
    localparam logic [1:0] RUN_FAST_INT = 2'h2;
    localparam logic [1:0] PRI_CRYSTAL = 2'h0;
    localparam logic [1:0] PRI_CRYSTAL_PLL = 2'h1;
    localparam logic [1:0] PRI_EXTERNAL = 2'h2;
    localparam logic [1:0] PRI_INTERNAL = 2'h3;
    localparam logic [2:0] FREQ_1MHZ = 3'h3;
    localparam logic [7:0] CFG_RESET = {1'b0, FREQ_1MHZ, PRI_CRYSTAL, RUN_PRIMARY};
    localparam int ST_PRI_READY = 0;
    localparam int ST_INT_STABLE = 1;
    localparam int ST_CPU_HELD = 2;
    localparam int ST_LOW_POWER = 3;
    // ****************************************************************
    // Clock source before wake-up, used as one key of the delay lookup.
    // ****************************************************************
    typedef enum logic [1:0] {SRC_NONE, SRC_PRIMARY, SRC_SLOW, SRC_FAST} before_src_e;
    // ****************************************************************
    // Timing: times in their own units, counts derived at 125 MHz.
    // ****************************************************************
    localparam int CLK_MHZ = 125;
    localparam int CPU_READY_NS = 200;
    localparam int CPU_READY_CYC = (CPU_READY_NS * CLK_MHZ + 999) / 1000;
    localparam int OSC_STARTUP_CYC = 1024;
    localparam int PLL_LOCK_US = 2000;
    localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
    localparam int INT_SETTLE_US = 5;
    localparam int INT_SETTLE_CYC = INT_SETTLE_US * CLK_MHZ;
    localparam int NUM_PERIPH = 8;
endpackage : wake_gate_pkg
`default_nettype wire

// ==== logic/wake_delay_gate.sv ====
// Wake-up exit delay sequencer with clock ready flags and a peripheral disable bank.
//
// Functional notes
// - No start-up timer leaving primary idle.
// - Skip start-up timer for non-crystal primary.
// - Hold CPU cpu_ready_delay, then run.
// - CPU ready delay runs alongside others.
// - Reset selects 1 MHz fast oscillator.
// - Crystal wake waits start-up, sets ready.
// - PLL wake waits start-up then lock.
// - Fast internal wake runs while settling.
// - All fast internal frequencies share category.
// - Disable bit cuts peripheral clocks.
// - Disabled peripheral ignores writes, reads invalid.
// - One disconnects, zero connects the module.
// - Serial ports bits 7,6; timers 5..0.
// - Wake only on interrupt, reset, watchdog.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module wake_delay_gate #(
    parameter int CNT_W = 20,
    parameter int CPU_READY_CYCLES = wake_gate_pkg::CPU_READY_CYC,
    parameter int OSC_STARTUP_CYCLES = wake_gate_pkg::OSC_STARTUP_CYC,
    parameter int PLL_LOCK_CYCLES = wake_gate_pkg::PLL_LOCK_CYC,
    parameter int INT_SETTLE_CYCLES = wake_gate_pkg::INT_SETTLE_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register port.
    input wire logic [wake_gate_pkg::ADDR_W-1:0] regAddr,
    input wire logic [wake_gate_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [wake_gate_pkg::DATA_W-1:0] regRdata,
    // Power-managed mode control from the core.
    input wire logic sleepReq,
    input wire logic intWake,
    input wire logic resetWake,
    input wire logic wdtWake,
    // CPU and clock status.
    output logic cpuRun,
    output logic primaryOscReadyFlag,
    output logic internalOscStableFlag,
    output logic [2:0] fastOscFreqSel,
    output logic primaryOscEn,
    output logic pllEn,
    // Peripheral gating, one lane per disable bit.
    input wire logic [wake_gate_pkg::NUM_PERIPH-1:0] periphWrReq,
    output logic [wake_gate_pkg::NUM_PERIPH-1:0] periphClkEn,
    output logic [wake_gate_pkg::NUM_PERIPH-1:0] periphWrEn,
    output logic [wake_gate_pkg::NUM_PERIPH-1:0] periphRdValid
);

    // ****************************************************************
    // Types and declarations.
    // ****************************************************************
    typedef enum logic [1:0] {ST_RUN, ST_LOWPWR, ST_WAKE} pm_state_e;

    pm_state_e state_r;
    wake_gate_pkg::before_src_e beforeSrc_r;
    logic [7:0] gate0_r;
    logic [7:0] cfg_r;
    logic idleMode_r;
    logic [CNT_W-1:0] csdCnt_r;
    logic [CNT_W-1:0] oscCnt_r;
    logic [CNT_W-1:0] pllCnt_r;
    logic [CNT_W-1:0] settleCnt_r;
    logic oscActive_r;
    logic pllActive_r;
    logic settleActive_r;
    logic priReady_r;
    logic intStable_r;
    logic wakeEvent;
    logic needOst;
    logic needPll;
    logic needSettle;
    logic keepIntStable;
    logic [1:0] runSrc;
    logic [1:0] priMode;
    logic csdDone;
    logic oscDone;
    logic [2:0] path;

    localparam logic [CNT_W-1:0] CSD_LOAD = CNT_W'(CPU_READY_CYCLES - 1);
    localparam logic [CNT_W-1:0] OST_LOAD = CNT_W'(OSC_STARTUP_CYCLES - 1);
    localparam logic [CNT_W-1:0] PLL_LOAD = CNT_W'(PLL_LOCK_CYCLES - 1);
    localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(INT_SETTLE_CYCLES - 1);

    // ****************************************************************
    // Delay path lookup.
    // ****************************************************************
    // Returns {start-up timer, PLL lock, internal settle} for a wake-up
    // from the given source into the given run target.
    function automatic logic [2:0] wakePath(
        input wake_gate_pkg::before_src_e src,
        input logic [1:0] run,
        input logic [1:0] pri
    );
        logic [2:0] res;
        res = 3'h0;
        if (src == wake_gate_pkg::SRC_PRIMARY)
        begin
            res = 3'h0;
        end
        else if (run == wake_gate_pkg::RUN_PRIMARY)
        begin
            case (pri)
                wake_gate_pkg::PRI_CRYSTAL: res = 3'h4;
                wake_gate_pkg::PRI_CRYSTAL_PLL: res = 3'h6;
                wake_gate_pkg::PRI_INTERNAL: res = 3'h1;
                default: res = 3'h0;
            endcase
        end
        else if (run == wake_gate_pkg::RUN_FAST_INT)
        begin
            // Every postscaler setting counts as the same source.
            res = (src == wake_gate_pkg::SRC_FAST) ? 3'h0 : 3'h1;
        end
        return res;
    endfunction : wakePath

    // ****************************************************************
    // Combinational decode.
    // ****************************************************************
    // Only these three events leave a power-managed mode.
    assign wakeEvent = intWake | resetWake | wdtWake;
    assign runSrc = cfg_r[wake_gate_pkg::CFG_RUN_LSB +: 2];
    assign priMode = cfg_r[wake_gate_pkg::CFG_PRI_LSB +: 2];
    assign path = wakePath(beforeSrc_r, runSrc, priMode);
    assign needOst = path[2];
    assign needPll = path[1];
    assign needSettle = path[0];
    assign keepIntStable = (beforeSrc_r == wake_gate_pkg::SRC_FAST);
    assign csdDone = (csdCnt_r == '0);
    assign oscDone = !oscActive_r && !pllActive_r;

    // ****************************************************************
    // Power-mode state machine.
    // ****************************************************************
    // Reset is itself treated as a wake from sleep, so the oscillator
    // path is qualified before the first instruction runs.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state_r <= ST_WAKE;
        else
        begin
            case (state_r)
                ST_RUN:
                    if (sleepReq)
                        state_r <= ST_LOWPWR;
                ST_LOWPWR:
                    if (wakeEvent)
                        state_r <= ST_WAKE;
                // Both delays must be over; neither adds to the other.
                ST_WAKE:
                    if (csdDone && oscDone)
                        state_r <= ST_RUN;
                default: state_r <= ST_WAKE;
            endcase
        end
    end

    // Remember which clock the device was on while it slept or idled.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            beforeSrc_r <= wake_gate_pkg::SRC_NONE;
            idleMode_r <= 1'b0;
        end
        else if (state_r == ST_RUN && sleepReq)
        begin
            idleMode_r <= cfg_r[wake_gate_pkg::CFG_IDLE_BIT];
            if (!cfg_r[wake_gate_pkg::CFG_IDLE_BIT])
            begin
                beforeSrc_r <= wake_gate_pkg::SRC_NONE;
            end
            else
            begin
                case (runSrc)
                    wake_gate_pkg::RUN_PRIMARY: beforeSrc_r <= wake_gate_pkg::SRC_PRIMARY;
                    wake_gate_pkg::RUN_FAST_INT: beforeSrc_r <= wake_gate_pkg::SRC_FAST;
                    default: beforeSrc_r <= wake_gate_pkg::SRC_SLOW;
                endcase
            end
        end
    end

    // ****************************************************************
    // Delay counters.
    // ****************************************************************
    // The CPU ready delay is loaded at the wake event in every case.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            csdCnt_r <= CSD_LOAD;
        else if (state_r == ST_LOWPWR && wakeEvent)
            csdCnt_r <= CSD_LOAD;
        else if (state_r == ST_WAKE && !csdDone)
            csdCnt_r <= csdCnt_r - CNT_W'(1);
    end

    // Start-up timer, then PLL lock, in series when both are needed.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            oscActive_r <= 1'b1;
            pllActive_r <= 1'b0;
            oscCnt_r <= OST_LOAD;
            pllCnt_r <= PLL_LOAD;
        end
        else if (state_r == ST_LOWPWR && wakeEvent)
        begin
            oscActive_r <= needOst;
            pllActive_r <= 1'b0;
            oscCnt_r <= OST_LOAD;
            pllCnt_r <= PLL_LOAD;
        end
        else if (oscActive_r)
        begin
            if (oscCnt_r == '0)
            begin
                oscActive_r <= 1'b0;
                pllActive_r <= needPll;
            end
            else
            begin
                oscCnt_r <= oscCnt_r - CNT_W'(1);
            end
        end
        else if (pllActive_r)
        begin
            if (pllCnt_r == '0)
            begin
                pllActive_r <= 1'b0;
            end
            else
            begin
                pllCnt_r <= pllCnt_r - CNT_W'(1);
            end
        end
    end

    // Internal oscillator settling; the CPU does not wait for it.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            settleActive_r <= 1'b0;
            settleCnt_r <= SETTLE_LOAD;
        end
        else if (state_r == ST_LOWPWR && wakeEvent)
        begin
            settleActive_r <= needSettle;
            settleCnt_r <= SETTLE_LOAD;
        end
        else if (settleActive_r)
        begin
            if (settleCnt_r == '0)
                settleActive_r <= 1'b0;
            else
                settleCnt_r <= settleCnt_r - CNT_W'(1);
        end
    end

    // ****************************************************************
    // Clock ready flags.
    // ****************************************************************
    // Primary ready drops whenever the primary clock is stopped and
    // rises once its start-up path is complete.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            priReady_r <= 1'b0;
        else if (state_r == ST_RUN && sleepReq)
            priReady_r <= cfg_r[wake_gate_pkg::CFG_IDLE_BIT]
                && runSrc == wake_gate_pkg::RUN_PRIMARY;
        else if (state_r == ST_WAKE && oscDone && runSrc == wake_gate_pkg::RUN_PRIMARY
                 && priMode != wake_gate_pkg::PRI_INTERNAL)
            priReady_r <= 1'b1;
    end

    // Internal stable stays set when the fast source kept running.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            intStable_r <= 1'b0;
        else if (state_r == ST_RUN && sleepReq)
            intStable_r <= cfg_r[wake_gate_pkg::CFG_IDLE_BIT]
                && runSrc == wake_gate_pkg::RUN_FAST_INT;
        else if (state_r == ST_LOWPWR && wakeEvent)
            intStable_r <= keepIntStable;
        else if (state_r != ST_LOWPWR && settleActive_r && settleCnt_r == '0)
            intStable_r <= 1'b1;
    end

    // ****************************************************************
    // Registers.
    // ****************************************************************
    // Disable bank; a one gates its peripheral off.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            gate0_r <= wake_gate_pkg::GATE0_RESET;
        else if (regWr && regAddr == wake_gate_pkg::ADDR_GATE0)
            gate0_r <= regWdata[7:0];
    end

    // Clock configuration; reset picks the 1 MHz fast oscillator.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cfg_r <= wake_gate_pkg::CFG_RESET;
        else if (regWr && regAddr == wake_gate_pkg::ADDR_CLKCFG)
            cfg_r <= regWdata[7:0];
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            regRdata <= '0;
        else if (regRd)
        begin
            case (regAddr)
                wake_gate_pkg::ADDR_GATE0: regRdata <= {24'h000000, gate0_r};
                wake_gate_pkg::ADDR_CLKCFG: regRdata <= {24'h000000, cfg_r};
                wake_gate_pkg::ADDR_STATUS: regRdata <= {28'h0000000, state_r == ST_LOWPWR,
                    !cpuRun, intStable_r, priReady_r};
                default: regRdata <= '0;
            endcase
        end
        else
            regRdata <= '0;
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    // Execution resumes on the first clock after the delays end.
    assign cpuRun = (state_r == ST_RUN);
    assign primaryOscReadyFlag = priReady_r;
    assign internalOscStableFlag = intStable_r;
    assign fastOscFreqSel = cfg_r[wake_gate_pkg::CFG_FREQ_LSB +: 3];
    // The primary oscillator keeps running in primary idle only.
    assign primaryOscEn = (state_r != ST_LOWPWR) || (idleMode_r
        && beforeSrc_r == wake_gate_pkg::SRC_PRIMARY);
    assign pllEn = primaryOscEn && priMode == wake_gate_pkg::PRI_CRYSTAL_PLL;

    // Per-peripheral gating; register state is kept while gated.
    for (genvar i = 0; i < wake_gate_pkg::NUM_PERIPH; i++)
    begin : g_gate
        assign periphClkEn[i] = !gate0_r[i];
        assign periphWrEn[i] = periphWrReq[i] && !gate0_r[i];
        assign periphRdValid[i] = !gate0_r[i];
    end

endmodule : wake_delay_gate
`default_nettype wire

// ==== logic/unused_placeholder_none.sv ====
// This file holds no logic; the design is complete in the files above.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ==== verification/wake_delay_gate_chk.sv ====
// Port-level checker for the wake delay sequencer and peripheral gate bank.
`timescale 1ns/1ns
`default_nettype none
module wake_delay_gate_chk #(
    parameter int CPU_READY_CYCLES = 25,
    parameter int OSC_STARTUP_CYCLES = 1024
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register port.
    input wire logic [wake_gate_pkg::ADDR_W-1:0] regAddr,
    input wire logic [wake_gate_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    // Mode control and wake events.
    input wire logic sleepReq,
    input wire logic intWake,
    input wire logic resetWake,
    input wire logic wdtWake,
    // CPU and clock status.
    input wire logic cpuRun,
    input wire logic primaryOscReadyFlag,
    input wire logic [2:0] fastOscFreqSel,
    input wire logic primaryOscEn,
    input wire logic pllEn,
    // Peripheral gating.
    input wire logic [wake_gate_pkg::NUM_PERIPH-1:0] periphWrReq,
    input wire logic [wake_gate_pkg::NUM_PERIPH-1:0] periphClkEn,
    input wire logic [wake_gate_pkg::NUM_PERIPH-1:0] periphWrEn,
    input wire logic [wake_gate_pkg::NUM_PERIPH-1:0] periphRdValid
);
    logic [7:0] wrByte;
    logic anyWake;
    logic wakeSeen;
    int wakeCnt;
    int oscCnt;
    logic xtalMode;
    assign wrByte = regWdata[7:0];
    assign anyWake = intWake | resetWake | wdtWake;
    // Cycles since the last wake event; saturates so a long sleep cannot wrap it.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wakeCnt <= 0;
        else if (cpuRun || anyWake)
            wakeCnt <= 0;
        else if (wakeCnt < 100000)
            wakeCnt <= wakeCnt + 1;
    end
    // Cycles the primary oscillator has run without a break.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            oscCnt <= 0;
        else if (!primaryOscEn)
            oscCnt <= 0;
        else if (oscCnt < 100000)
            oscCnt <= oscCnt + 1;
    end
    // Shadow of the primary mode; only crystal modes owe the start-up time,
    // an external clock may report ready at once.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            xtalMode <= 1'b1;
        else if (regWr && regAddr == wake_gate_pkg::ADDR_CLKCFG)
            xtalMode <= wrByte[wake_gate_pkg::CFG_PRI_LSB +: 2] == wake_gate_pkg::PRI_CRYSTAL
                || wrByte[wake_gate_pkg::CFG_PRI_LSB +: 2] == wake_gate_pkg::PRI_CRYSTAL_PLL;
    end
    // Reset counts as a wake cause; entering a low-power mode clears it.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wakeSeen <= 1'b1;
        else if (cpuRun && sleepReq)
            wakeSeen <= 1'b0;
        else if (anyWake)
            wakeSeen <= 1'b1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ****************************************************************
    // Assertions.
    // ****************************************************************
    a_gate_rd_valid: assert property (periphRdValid == periphClkEn)
        else $error("read valid lanes differ from clock enables");
    a_gate_wr_block: assert property (periphWrEn == (periphWrReq & periphClkEn))
        else $error("write reached a disabled peripheral");
    a_gate_write_map: assert property (regWr && regAddr == wake_gate_pkg::ADDR_GATE0
        |=> periphClkEn == ~$past(wrByte)) else $error("clock enables do not follow gate write");
    a_reset_freq_sel: assert property ($fell(rst) |->
        fastOscFreqSel == wake_gate_pkg::FREQ_1MHZ) else $error("frequency not 1 MHz after reset");
    a_cpu_ready_hold: assert property ($rose(cpuRun) |-> wakeCnt >= CPU_READY_CYCLES)
        else $error("CPU released before the ready delay");
    a_wake_cause: assert property ($rose(cpuRun) |-> wakeSeen)
        else $error("CPU woke without a wake event");
    a_osc_startup: assert property ($rose(primaryOscReadyFlag) && xtalMode |->
        oscCnt >= OSC_STARTUP_CYCLES) else $error("primary ready before start-up time");
    a_pll_on_osc: assert property (pllEn |-> primaryOscEn)
        else $error("PLL enabled without primary oscillator");
endmodule : wake_delay_gate_chk
bind wake_delay_gate wake_delay_gate_chk #(
    .CPU_READY_CYCLES(CPU_READY_CYCLES),
    .OSC_STARTUP_CYCLES(OSC_STARTUP_CYCLES)
) u_chk (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .sleepReq(sleepReq), .intWake(intWake), .resetWake(resetWake), .wdtWake(wdtWake),
    .cpuRun(cpuRun), .primaryOscReadyFlag(primaryOscReadyFlag),
    .fastOscFreqSel(fastOscFreqSel), .primaryOscEn(primaryOscEn), .pllEn(pllEn),
    .periphWrReq(periphWrReq), .periphClkEn(periphClkEn), .periphWrEn(periphWrEn),
    .periphRdValid(periphRdValid)
);
`default_nettype wire

// ==== verification/tb_wake_delay_gate.sv ====
// Self-checking testbench for the wake delay sequencer and peripheral gate bank.
`timescale 1ns/1ns
`default_nettype none
module tb_wake_delay_gate;
    // Shortened counts keep the run brief; every delay expectation derives from them.
    localparam int CPU = 5;
    localparam int STARTUP_TIMER = 16;
    localparam int PLL = 40;
    localparam int SET = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic sleepReq = 1'b0;
    logic intWake = 1'b0;
    logic resetWake = 1'b0;
    logic wdtWake = 1'b0;
    logic [7:0] periphWrReq = 8'h00;
    logic [31:0] regRdata;
    logic cpuRun, primaryOscReadyFlag, internalOscStableFlag, primaryOscEn, pllEn;
    logic [2:0] fastOscFreqSel;
    logic [7:0] periphClkEn, periphWrEn, periphRdValid;
    logic [31:0] d;
    int n;
    int error_cnt = 0;
    int comparisons = 0;
    // Wake cases: config byte, wake source, allowed exit delay span.
    logic [7:0] cfgT [7] = '{8'h30, 8'hb0, 8'h34, 8'h38, 8'h3c, 8'h3e, 8'hfe};
    int evT [7] = '{0, 1, 2, 1, 0, 2, 0};
    int loT [7] = '{STARTUP_TIMER-1, CPU-1, STARTUP_TIMER+PLL-1, CPU-1, CPU-1, CPU-1, CPU-1};
    int hiT [7] = '{STARTUP_TIMER+3, CPU+3, STARTUP_TIMER+PLL+4, CPU+3, CPU+3, CPU+3, CPU+3};
    wake_delay_gate #(.CPU_READY_CYCLES(CPU), .OSC_STARTUP_CYCLES(STARTUP_TIMER),
        .PLL_LOCK_CYCLES(PLL), .INT_SETTLE_CYCLES(SET)) u_dut (
        .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .sleepReq(sleepReq), .intWake(intWake),
        .resetWake(resetWake), .wdtWake(wdtWake), .cpuRun(cpuRun),
        .primaryOscReadyFlag(primaryOscReadyFlag), .internalOscStableFlag(internalOscStableFlag),
        .fastOscFreqSel(fastOscFreqSel), .primaryOscEn(primaryOscEn), .pllEn(pllEn),
        .periphWrReq(periphWrReq), .periphClkEn(periphClkEn), .periphWrEn(periphWrEn),
        .periphRdValid(periphRdValid));
    // Free-running 125 MHz clock.
    initial
    begin
        forever #4 clk = ~clk;
    end
    task automatic chkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chkVal
    task automatic chkSpan(input string what, input int lo, input int hi, input int got);
        comparisons++;
        if (got < lo || got > hi)
        begin
            error_cnt++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
        end
    endtask : chkSpan
    task automatic regWrite(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : regWrite
    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic regRead(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask : regRead
    // Bounded wait for the CPU to run, counting cycles.
    task automatic waitRun(output int cnt);
        cnt = 0;
        #1;
        while (cpuRun !== 1'b1 && cnt < 500)
        begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask : waitRun
    task automatic wakeCycle(input logic [7:0] cfg, input int ev, output int cnt);
        regWrite(wake_gate_pkg::ADDR_CLKCFG, {24'h0, cfg});
        @(posedge clk);
        sleepReq <= 1'b1;
        @(posedge clk);
        sleepReq <= 1'b0;
        repeat (40) @(posedge clk);
        #1 chkVal("cpu held asleep", 32'h0, {31'h0, cpuRun});
        chkVal("primary osc asleep", {31'h0, cfg[wake_gate_pkg::CFG_IDLE_BIT] &&
            cfg[wake_gate_pkg::CFG_RUN_LSB +: 2] == wake_gate_pkg::RUN_PRIMARY},
            {31'h0, primaryOscEn});
        regRead(wake_gate_pkg::ADDR_STATUS, d);
        chkVal("status asleep", 32'hc, d & 32'hc);
        @(posedge clk);
        {intWake, resetWake, wdtWake} <= 3'b100 >> ev;
        @(posedge clk);
        {intWake, resetWake, wdtWake} <= 3'b000;
        waitRun(cnt);
    endtask : wakeCycle
    task automatic results();
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    // Watchdog: the sequence needs about 560 cycles.
    initial
    begin
        #100000;
        error_cnt++;
        $display("unexpected run length: expected finish, seen hang");
        results();
    end
    // Main sequence.
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        regRead(wake_gate_pkg::ADDR_GATE0, d);
        chkVal("gate0 reset", {24'h0, wake_gate_pkg::GATE0_RESET}, d);
        regRead(wake_gate_pkg::ADDR_CLKCFG, d);
        chkVal("clkcfg reset", {24'h0, wake_gate_pkg::CFG_RESET}, d);
        chkVal("freq sel", {29'h0, wake_gate_pkg::FREQ_1MHZ}, {29'h0, fastOscFreqSel});
        chkVal("clock enables reset", 32'hff, {24'h0, periphClkEn});
        // Disable each lane alone; writes must pass only to enabled lanes.
        @(posedge clk) periphWrReq <= 8'hb7;
        for (int i = 0; i < 8; i++)
        begin
            regWrite(wake_gate_pkg::ADDR_GATE0, 32'h1 << i);
            #1 chkVal("clock enables", {24'h0, ~(8'h1 << i)}, {24'h0, periphClkEn});
            chkVal("write enables", {24'h0, 8'hb7 & ~(8'h1 << i)}, {24'h0, periphWrEn});
            chkVal("read valid", {24'h0, ~(8'h1 << i)}, {24'h0, periphRdValid});
            regRead(wake_gate_pkg::ADDR_GATE0, d);
            chkVal("gate0 readback", 32'h1 << i, d);
        end
        regWrite(wake_gate_pkg::ADDR_GATE0, 32'h1a5);
        regWrite(8'h0c, 32'hff);
        regRead(8'h0c, d);
        chkVal("unmapped read", 32'h0, d);
        regRead(wake_gate_pkg::ADDR_GATE0, d);
        chkVal("gate0 upper bits", 32'ha5, d);
        regWrite(wake_gate_pkg::ADDR_GATE0, 32'h0);
        waitRun(n);
        // Seven before/after source pairs, none from the secondary clock; wake causes cycle through all three.
        for (int r = 0; r < 7; r++)
        begin
            wakeCycle(cfgT[r], evT[r], n);
            chkSpan("exit delay", loT[r], hiT[r], n);
            if (r < 3)
                chkVal("primary ready", 32'h1, {31'h0, primaryOscReadyFlag});
            if (r == 2)
                chkVal("pll enable", 32'h1, {31'h0, pllEn});
            if (r > 4)
            begin
                repeat (SET + 5) @(posedge clk);
                #1 chkVal("settle flag", 32'h1, {31'h0, internalOscStableFlag});
            end
        end
        chkVal("freq sel", 32'h7, {29'h0, fastOscFreqSel});
        regRead(wake_gate_pkg::ADDR_STATUS, d);
        chkVal("status", 32'h1 << wake_gate_pkg::ST_INT_STABLE, d);
        // A mid-run reset must restore the defaults and wake as from sleep.
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        waitRun(n);
        chkSpan("reset exit delay", STARTUP_TIMER-1, STARTUP_TIMER+3, n);
        regRead(wake_gate_pkg::ADDR_CLKCFG, d);
        chkVal("clkcfg reset", {24'h0, wake_gate_pkg::CFG_RESET}, d);
        results();
    end
endmodule : tb_wake_delay_gate
`default_nettype wire
